// File: verilog/gpa_pkg.sv
package gpa_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int GPA_NPORT = 4;
  localparam int GPA_NAIN = 12;
  localparam int GPA_ADR_W = 10;
  localparam int GPA_CHS_W = 4;

  typedef logic [7:0] gpa_byte_t;

  // ---------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam gpa_byte_t GPA_IDX_OD0 = 8'h9c;
  localparam gpa_byte_t GPA_IDX_OD1 = 8'h9d;
  localparam gpa_byte_t GPA_IDX_PCON4 = 8'hc6;
  localparam gpa_byte_t GPA_IDX_PCON5 = 8'hc7;
  localparam gpa_byte_t GPA_IDX_ADM = 8'hc8;
  // Port order in all arrays: port 0, port 1, port 4, port 5
  localparam gpa_byte_t GPA_IDX_DIR [GPA_NPORT] = '{8'ha0, 8'ha1, 8'ha4, 8'ha5};
  localparam gpa_byte_t GPA_IDX_DAT [GPA_NPORT] = '{8'ha6, 8'ha7, 8'haa, 8'hab};
  localparam gpa_byte_t GPA_IDX_PU [GPA_NPORT] = '{8'hac, 8'had, 8'hb0, 8'hb1};
  localparam gpa_byte_t GPA_PORT_MASK [GPA_NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h0f};

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam gpa_byte_t GPA_RST_BYTE = 8'h00;
  localparam gpa_byte_t GPA_OD0_MASK = 8'h03;
  localparam gpa_byte_t GPA_PORT5_ANALOG_CONFIG_MASK = 8'h0f;
  localparam int GPA_OD0_PIN_LSB = 2;
  localparam int GPA_ADM_GLOBAL_CHANNEL_ENABLE_BIT = 4;
  localparam int GPA_ADM_CHS_LSB = 0;
  localparam int GPA_RSTPIN_BIT = 4;
  localparam int GPA_P5_AIN_BASE = 8;

  typedef struct packed {
    gpa_byte_t dout;
    gpa_byte_t oe;
    gpa_byte_t pu;
    gpa_byte_t ana;
  } gpa_pad_s;

endpackage : gpa_pkg

// File: verilog/gpa_top.sv
// Function
// - Pull-up acts only while the pin is an input.
// - Pull-up enable bit 1 enables, 0 disables that pin's pull-up.
// - Data read returns pin levels; data write loads the output latch.
// - With reset-pin option selected, port 0 bit 4 reads as 1.
// - At most one port 4/5 pin is selected as the analog input channel at a time.
// - Analog config bit 1 forces input and pull-up off; 0 is digital.
// - Channel enable 0 leaves port 4/5 pins digital unless their analog config bit is set.
// - Channel enable 1 makes the selected pin analog, overriding digital use.
// - Channel select n picks input n for 0..11; other codes pick none.
// - Channel enable is converter mode bit 4, select is bits 3:0.
// - Open-drain exists only on port 0 pins 2, 3 and all of port 1.
// - Open-drain sinks a low output and releases a high one.
// - Port 0 open-drain: bit 0 for pin 2, bit 1 for pin 3.
// - Port 1 open-drain: one bit per pin, 1 enables.
// - Clearing open-drain restores the previous mode unchanged.
// - Direction bit 0 makes an input, 1 makes an output.
`timescale 1ns/1ns
`default_nettype none

module gpa_top
  import gpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [GPA_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic reset_pin_opt_i,
  input wire logic [GPA_NPORT-1:0][7:0] pad_in_i,
  output var gpa_pad_s [GPA_NPORT-1:0] pad_o,
  output logic [GPA_NAIN-1:0] analog_input_o
);

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic req_w;
  logic wr_w;
  gpa_byte_t idx_w;
  gpa_byte_t rd_d;

  assign idx_w = adr_i[GPA_ADR_W-1:2];
  assign req_w = cyc_i & stb_i & ~ack_q;
  // Write lands on the edge that ends the cycle, as the master sees it
  assign wr_w = cyc_i & stb_i & ack_q & we_i & sel_i[0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_w;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [GPA_NPORT-1:0][7:0] dir_q;
  logic [GPA_NPORT-1:0][7:0] lat_q;
  logic [GPA_NPORT-1:0][7:0] pu_q;
  gpa_byte_t od0_q;
  gpa_byte_t od1_q;
  gpa_byte_t pcon4_q;
  gpa_byte_t pcon5_q;
  gpa_byte_t adm_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      od0_q <= GPA_RST_BYTE;
    end else if (wr_w && idx_w == GPA_IDX_OD0) begin
      od0_q <= dat_i[7:0] & GPA_OD0_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      od1_q <= GPA_RST_BYTE;
    end else if (wr_w && idx_w == GPA_IDX_OD1) begin
      od1_q <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcon4_q <= GPA_RST_BYTE;
    end else if (wr_w && idx_w == GPA_IDX_PCON4) begin
      pcon4_q <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcon5_q <= GPA_RST_BYTE;
    end else if (wr_w && idx_w == GPA_IDX_PCON5) begin
      pcon5_q <= dat_i[7:0] & GPA_PORT5_ANALOG_CONFIG_MASK;
    end
  end

  // Converter bits other than enable/select are stored for software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adm_q <= GPA_RST_BYTE;
    end else if (wr_w && idx_w == GPA_IDX_ADM) begin
      adm_q <= dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Analog channel select
  // ---------------------------------------------------------------
  logic global_channel_enable_w;
  logic [GPA_CHS_W-1:0] chs_w;
  logic [GPA_NAIN-1:0] chsel_w;

  assign global_channel_enable_w = adm_q[GPA_ADM_GLOBAL_CHANNEL_ENABLE_BIT];
  assign chs_w = adm_q[GPA_ADM_CHS_LSB +: GPA_CHS_W];

  // Codes above 11 match no bit, so no pin turns analog
  for (genvar i = 0; i < GPA_NAIN; i++) begin : g_chs
    assign chsel_w[i] = global_channel_enable_w & (chs_w == GPA_CHS_W'(i));
  end

  // ---------------------------------------------------------------
  // Per-port overrides
  // ---------------------------------------------------------------
  logic [GPA_NPORT-1:0][7:0] ana_w;
  logic [GPA_NPORT-1:0][7:0] od_w;

  assign ana_w[0] = 8'h00;
  assign ana_w[1] = 8'h00;
  assign ana_w[2] = pcon4_q | chsel_w[7:0];
  assign ana_w[3] = pcon5_q | {4'h0, chsel_w[GPA_NAIN-1:GPA_P5_AIN_BASE]};
  assign od_w[0] = {od0_q[5:0], 2'b00} << (GPA_OD0_PIN_LSB - 2) & (GPA_OD0_MASK << GPA_OD0_PIN_LSB);
  assign od_w[1] = od1_q;
  assign od_w[2] = 8'h00;
  assign od_w[3] = 8'h00;
  assign analog_input_o = chsel_w;

  // ---------------------------------------------------------------
  // Ports: registers, pin sampling, pad drive
  // ---------------------------------------------------------------
  logic [GPA_NPORT-1:0][7:0] s1_q;
  logic [GPA_NPORT-1:0][7:0] s2_q;
  logic [GPA_NPORT-1:0][7:0] s3_q;
  logic [GPA_NPORT-1:0][7:0] lvl_q;
  logic [GPA_NPORT-1:0][7:0] out_en_w;
  gpa_pad_s [GPA_NPORT-1:0] pad_d;
  gpa_pad_s [GPA_NPORT-1:0] pad_q;

  for (genvar k = 0; k < GPA_NPORT; k++) begin : g_port
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dir_q[k] <= GPA_RST_BYTE;
      end else if (wr_w && idx_w == GPA_IDX_DIR[k]) begin
        dir_q[k] <= dat_i[7:0] & GPA_PORT_MASK[k];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lat_q[k] <= GPA_RST_BYTE;
      end else if (wr_w && idx_w == GPA_IDX_DAT[k]) begin
        lat_q[k] <= dat_i[7:0] & GPA_PORT_MASK[k];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pu_q[k] <= GPA_RST_BYTE;
      end else if (wr_w && idx_w == GPA_IDX_PU[k]) begin
        pu_q[k] <= dat_i[7:0] & GPA_PORT_MASK[k];
      end
    end

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q[k] <= GPA_RST_BYTE;
        s2_q[k] <= GPA_RST_BYTE;
        s3_q[k] <= GPA_RST_BYTE;
        lvl_q[k] <= GPA_RST_BYTE;
      end else begin
        s1_q[k] <= pad_in_i[k];
        s2_q[k] <= s1_q[k];
        s3_q[k] <= s2_q[k];
        lvl_q[k] <= (s2_q[k] & s3_q[k]) | (lvl_q[k] & (s2_q[k] | s3_q[k]));
      end
    end

    // Analog forces input; open-drain only gates drive, never direction
    assign out_en_w[k] = dir_q[k] & ~ana_w[k];
    assign pad_d[k].oe = out_en_w[k] & ~(od_w[k] & lat_q[k]);
    assign pad_d[k].dout = lat_q[k] & ~od_w[k];
    assign pad_d[k].pu = pu_q[k] & ~out_en_w[k] & ~ana_w[k];
    assign pad_d[k].ana = ana_w[k];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  assign pad_o = pad_q;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    case (idx_w)
      GPA_IDX_OD0: rd_d = od0_q;
      GPA_IDX_OD1: rd_d = od1_q;
      GPA_IDX_PCON4: rd_d = pcon4_q;
      GPA_IDX_PCON5: rd_d = pcon5_q;
      GPA_IDX_ADM: rd_d = adm_q;
      default: rd_d = 8'h00;
    endcase
    for (int k = 0; k < GPA_NPORT; k++) begin
      if (idx_w == GPA_IDX_DIR[k]) begin
        rd_d = dir_q[k];
      end
      if (idx_w == GPA_IDX_PU[k]) begin
        rd_d = pu_q[k];
      end
      if (idx_w == GPA_IDX_DAT[k]) begin
        rd_d = lvl_q[k] & GPA_PORT_MASK[k];
      end
    end
    if (idx_w == GPA_IDX_DAT[0] && reset_pin_opt_i) begin
      rd_d[GPA_RSTPIN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (req_w) begin
      dat_q <= {24'h0, rd_d};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_PU_ONLY_INPUT: assert property (
    ((dir_q[1] & pu_q[1]) != 8'h00) |=> ((pad_o[1].pu & $past(dir_q[1])) == 8'h00))
    else $error("pull-up active on an output pin");

  AST_PU_FOLLOWS_ENABLE: assert property (
    (dir_q[1] == 8'h00) |=> (pad_o[1].pu == $past(pu_q[1])))
    else $error("pull-up does not follow enable on inputs");

  AST_LATCH_WRITE: assert property (
    (wr_w && idx_w == GPA_IDX_DAT[1]) |=> ##1 (pad_o[1].dout == ($past(dat_i[7:0], 2) & ~od1_q)))
    else $error("data write did not reach the latch");

  AST_RSTPIN_READ_ONE: assert property (
    (req_w && !we_i && idx_w == GPA_IDX_DAT[0] && reset_pin_opt_i) |=> (ack_o && dat_o[GPA_RSTPIN_BIT]))
    else $error("reset pin bit did not read as one");

  AST_ONE_ANALOG: assert property ($onehot0(analog_input_o))
    else $error("more than one analog channel selected");

  AST_PCON_FORCE: assert property (
    pcon4_q[0] |=> (pad_o[2].ana[0] && !pad_o[2].oe[0] && !pad_o[2].pu[0]))
    else $error("config bit did not force analog input");

  AST_GLOBAL_CHANNEL_ENABLE_OFF: assert property (!adm_q[GPA_ADM_GLOBAL_CHANNEL_ENABLE_BIT] |-> (analog_input_o == 12'h000))
    else $error("analog channel active with enable low");

  AST_CHS_P5: assert property (
    (adm_q[4:0] == 5'h19) |=> (pad_o[3].ana[1] && !pad_o[3].oe[1] && !pad_o[3].pu[1]))
    else $error("selected pin did not turn analog");

  AST_CHS_NONE: assert property ((adm_q[3:0] > 4'hb) |-> (analog_input_o == 12'h000))
    else $error("unlisted channel code selected a pin");

  AST_OD_SINK: assert property (
    (od1_q[0] && dir_q[1][0]) |=> (!pad_o[1].dout[0] && (pad_o[1].oe[0] == !$past(lat_q[1][0]))))
    else $error("open-drain pin drove high");

  AST_NO_OD_P4: assert property (
    (dir_q[2] == 8'hff && pcon4_q == 8'h00 && !adm_q[4]) |=> (pad_o[2].oe == 8'hff))
    else $error("port 4 lost drive");

  AST_DIR_OUT: assert property (
    (dir_q[1][3] && !od1_q[3]) |=> (pad_o[1].oe[3] && pad_o[1].dout[3] == $past(lat_q[1][3])))
    else $error("output pin not driven from latch");

  AST_PU_OFF_WHEN_CLEAR: assert property (
    (pu_q[2] == 8'h00) |=> (pad_o[2].pu == 8'h00))
    else $error("pull-up on with enable clear");

  AST_OD0_PIN2: assert property (
    (od0_q[0] && lat_q[0][2]) |=> !pad_o[0].oe[2])
    else $error("port 0 pin 2 drove high in open-drain");

  AST_OD0_PIN3: assert property (
    (od0_q[1] && dir_q[0][3] && !lat_q[0][3]) |=> (pad_o[0].oe[3] && !pad_o[0].dout[3]))
    else $error("port 0 pin 3 did not sink low");

  AST_OD0_MASK: assert property (od0_q[7:2] == 6'h00)
    else $error("unimplemented open-drain bit set");

  AST_OD_NONE_OTHERS: assert property (
    ((od_w[0] & 8'hf3) == 8'h00) && (od_w[2] == 8'h00) && (od_w[3] == 8'h00))
    else $error("open-drain on a pin without it");

  AST_OD1_RELEASE: assert property (
    (od1_q[5] && lat_q[1][5]) |=> (!pad_o[1].oe[5] && !pad_o[1].dout[5]))
    else $error("port 1 open-drain pin drove high");

  AST_OD_RESTORE: assert property (
    (!od1_q[6] && dir_q[1][6]) |=> pad_o[1].oe[6])
    else $error("output mode not restored after open-drain");

  AST_INPUT_NO_DRIVE: assert property (
    !dir_q[1][0] |=> !pad_o[1].oe[0])
    else $error("input pin driven");

  AST_CFG_ZERO_DIGITAL: assert property (
    (!pcon4_q[1] && !adm_q[4] && dir_q[2][1]) |=> pad_o[2].oe[1])
    else $error("digital pin lost drive");

  AST_CHS_P4: assert property (
    (adm_q[4:0] == 5'h13) |=> (pad_o[2].ana[3] && !pad_o[2].oe[3]))
    else $error("port 4 pin 3 did not turn analog");

  AST_CHS_P5_BIT: assert property (
    (adm_q[4:0] == 5'h1b) |-> analog_input_o[11])
    else $error("input 11 not on port 5 pin 3");

  AST_CHS_DECODE: assert property (
    (adm_q[4:0] == 5'h10) |-> (analog_input_o == 12'h001))
    else $error("code zero did not pick input zero");

  AST_GLOBAL_CHANNEL_ENABLE_BIT: assert property (
    (adm_q[4] && adm_q[3:0] == 4'h7) |-> analog_input_o[7])
    else $error("enable bit or select field misplaced");

  AST_ACK_PULSE: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  AST_READ_LEVEL: assert property (
    (req_w && !we_i && idx_w == GPA_IDX_DAT[3]) |=> (dat_o[7:4] == 4'h0))
    else $error("port 5 upper bits read nonzero");

  AST_DIGITAL_P5: assert property (
    (!adm_q[4] && pcon5_q == 8'h00) |=> (pad_o[3].ana == 8'h00))
    else $error("port 5 analog with enable low");

  AST_PU_OUTPUT_P4: assert property (
    (dir_q[2][0] && !ana_w[2][0]) |=> !pad_o[2].pu[0])
    else $error("pull-up on a port 4 output");

endmodule : gpa_top

`default_nettype wire

// File: tb/gpa_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

module gpa_pin_model
  import gpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gpa_pad_s [GPA_NPORT-1:0] pad_i,
  input wire logic [GPA_NPORT-1:0][7:0] ext_en_i,
  input wire logic [GPA_NPORT-1:0][7:0] ext_val_i,
  output logic [GPA_NPORT-1:0][7:0] lvl_o
);
  // ---------------------------------------------------------------
  // Pin level resolution
  // ---------------------------------------------------------------
  logic tgl_q;

  // Floating pins wander so a stale level is never read as valid
  always_ff @(posedge clk_i) begin
    if (rst_i) tgl_q <= 1'b0;
    else tgl_q <= ~tgl_q;
  end

  always_comb begin
    for (int k = 0; k < GPA_NPORT; k++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_i[k].oe[b]) lvl_o[k][b] = pad_i[k].dout[b];
        else if (ext_en_i[k][b]) lvl_o[k][b] = ext_val_i[k][b];
        else if (pad_i[k].pu[b]) lvl_o[k][b] = 1'b1;
        else lvl_o[k][b] = tgl_q ^ b[0];
      end
    end
  end
endmodule : gpa_pin_model

`default_nettype wire

// File: tb/test_gpa_top.sv
`timescale 1ns/1ns
`default_nettype none

module test_gpa_top
  import gpa_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic opt = 1'b0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic [31:0] rdv;
  logic ack_o;
  logic [3:0][7:0] pin;
  logic [3:0][7:0] een = '0;
  logic [3:0][7:0] eval = '0;
  gpa_pad_s [3:0] pad;
  logic [11:0] analog_input;
  int error_cnt = 0;
  int total_checks = 0;
  localparam gpa_byte_t RL [10] = '{GPA_IDX_OD0, GPA_IDX_OD1, GPA_IDX_PCON4, GPA_IDX_PCON5, GPA_IDX_ADM,
    GPA_IDX_PU[0], GPA_IDX_PU[1], GPA_IDX_DIR[2], GPA_IDX_PU[3], 8'h00};

  gpa_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .reset_pin_opt_i(opt), .pad_in_i(pin), .pad_o(pad), .analog_input_o(analog_input));
  gpa_pin_model pin_u (.clk_i(clk_i), .rst_i(rst_i), .pad_i(pad), .ext_en_i(een),
    .ext_val_i(eval), .lvl_o(pin));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Ack and data are read right after the edge, before the design's updates land
  task xfer(input logic w, input gpa_byte_t idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      error_cnt++;
      close_out;
    end
    rdv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : xfer

  task wr(input gpa_byte_t idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
    repeat (2) @(negedge clk_i);
  endtask : wr

  task rc(input gpa_byte_t idx, input logic [7:0] e);
    repeat (6) @(negedge clk_i);
    xfer(1'b0, idx, 8'h00);
    chk(rdv, {24'h0, e});
  endtask : rc

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    #200000;
    error_cnt++;
    close_out;
  end

  initial begin
    logic [11:0] e;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) rc(RL[i], 8'h00);
    for (int k = 0; k < 4; k++) chk(pad[k], 32'h0);
    wr(GPA_IDX_PU[2], 8'hff);
    chk(pad[2], 32'h0000ff00);
    wr(GPA_IDX_DIR[2], 8'h0f);
    chk(pad[2], 32'h000ff000);
    wr(GPA_IDX_PCON4, 8'h81);
    chk(pad[2], 32'h000e7081);
    for (int n = 0; n < 16; n++) begin
      wr(GPA_IDX_ADM, 8'h10 | n[7:0]);
      e = (n < 12) ? (12'h1 << n) : 12'h0;
      chk(analog_input, e);
      chk(pad[2].ana, e[7:0] | 8'h81);
      chk(pad[3].ana, e[11:8]);
    end
    wr(GPA_IDX_ADM, 8'h05);
    chk(analog_input, 32'h0);
    chk(pad[2].ana, 8'h81);
    rc(GPA_IDX_ADM, 8'h05);
    wr(GPA_IDX_DAT[1], 8'ha5);
    wr(GPA_IDX_DIR[1], 8'hff);
    chk(pad[1], 32'ha5ff0000);
    rc(GPA_IDX_DAT[1], 8'ha5);
    eval[1] <= 8'hff;
    een[1] <= 8'hff;
    wr(GPA_IDX_OD1, 8'hff);
    chk(pad[1], 32'h005a0000);
    rc(GPA_IDX_DAT[1], 8'ha5);
    wr(GPA_IDX_OD1, 8'h00);
    chk(pad[1], 32'ha5ff0000);
    wr(GPA_IDX_PU[1], 8'hff);
    chk(pad[1], 32'ha5ff0000);
    wr(GPA_IDX_DAT[0], 8'h04);
    wr(GPA_IDX_DIR[0], 8'h0c);
    wr(GPA_IDX_OD0, 8'hff);
    chk(pad[0], 32'h00080000);
    rc(GPA_IDX_OD0, 8'h03);
    een[0] <= 8'hff;
    opt <= 1'b1;
    rc(GPA_IDX_DAT[0], 8'h10);
    opt <= 1'b0;
    rc(GPA_IDX_DAT[0], 8'h00);
    eval[3] <= 8'hff;
    een[3] <= 8'hff;
    rc(GPA_IDX_DAT[3], 8'h0f);
    close_out;
  end
endmodule : test_gpa_top

`default_nettype wire
